// [ssbm_defines.svh]
// Constants for the select, single-pin and mode-fault logic of the serial interface.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SSBM_DEFINES_SVH
`define SSBM_DEFINES_SVH

// Reset value of the first control register image: slave, every feature off.
`define SSBM_CTRL1_RST      5'h00
// Field positions inside the first control register image.
`define SSBM_C1_RX_IRQ_EN   4
`define SSBM_C1_TX_IRQ_EN   3
`define SSBM_C1_MASTER      2
`define SSBM_C1_SEL_OUT_EN  1
`define SSBM_C1_FAULT_EN    0
// Reset values of the flags and of an idle pin drive.
`define SSBM_FLAG_RST       1'h0
`define SSBM_SELECT_IDLE    1'h1
`define SSBM_DRIVE_RST      2'h0
// Synchroniser reset values for a pin whose idle level is high, and for one whose idle level is low.
`define SSBM_SYNC_HIGH      2'h3
`define SSBM_SYNC_LOW       2'h0

`endif

// [ssbm_pkg.sv]
// Types shared by the select, single-pin and mode-fault logic.
// Assumes the constants header is on the include path.
`include "ssbm_defines.svh"

package ssbm_pkg;

	// First control register image, written as a whole by software.
	typedef struct packed {
		logic rx_fault_irq_enable;
		logic tx_irq_enable;
		logic master_select;
		logic select_output_enable;
		logic fault_detect_enable;
	} ssbm_ctrl1_type;

	// Second control register bits that steer the data pins.
	typedef struct packed {
		logic single_pin_mode;
		logic single_pin_output_enable;
	} ssbm_ctrl2_type;

	// One pin as seen by the pad: value to drive and its output enable.
	typedef struct packed {
		logic out;
		logic oe;
	} ssbm_drive_type;

endpackage

// [ssbm_core.sv]
// Select output, single-pin data mode, interrupt request and mode-fault logic of a
// serial interface. Assumes the transfer engine, clock generator and registers sit
// beside it on core_clk, and that link_clk is the serial clock of the shifter.
`timescale 1ns/1ps
`include "ssbm_defines.svh"

module ssbm_core
	import ssbm_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire logic           link_clk,
	input  wire logic           interface_enable,
	input  wire logic           ctrl_write,
	input  wire ssbm_ctrl1_type ctrl_wdata,
	input  wire ssbm_ctrl2_type ctrl2,
	input  wire logic           status_read,
	input  wire logic           rx_full_flag,
	input  wire logic           tx_empty_flag,
	input  wire logic           transfer_active,
	input  wire logic           shift_out_bit,
	input  wire logic           clock_gen_level,
	input  wire logic           select_pin_in,
	input  wire logic           master_data_io_in,
	input  wire logic           slave_data_io_in,
	output ssbm_ctrl1_type      ctrl1,
	output logic                fault_flag,
	output logic                irq,
	output ssbm_drive_type      serial_clock_pin,
	output ssbm_drive_type      select_pin,
	output ssbm_drive_type      master_data_io,
	output ssbm_drive_type      slave_data_io,
	output logic                shift_serial_in
);

	function automatic ssbm_drive_type make_drive(input logic enable, input logic value);
		make_drive.out = value;
		make_drive.oe  = enable;
	endfunction

	logic [1:0]     select_sync;
	logic           clear_armed;
	ssbm_ctrl2_type ctrl2_seen;

	// Core-side decode of the select pin and the fault condition.
	wire logic select_low         = ~select_sync[1];
	wire logic fault_input_active = interface_enable & ctrl1.master_select
		& ctrl1.fault_detect_enable & ~ctrl1.select_output_enable;
	wire logic fault_detect       = fault_input_active & select_low;
	wire logic clear_write        = ctrl_write & clear_armed;

	wire logic next_fault_flag  = fault_detect | (fault_flag & ~clear_write);
	wire logic next_clear_armed = fault_flag & (status_read | (clear_armed & ~ctrl_write));

	// A fault in the same cycle as a control write still forces slave mode.
	wire ssbm_ctrl1_type written_ctrl1 = ctrl_write ? ctrl_wdata : ctrl1;
	wire logic next_master = written_ctrl1.master_select & ~fault_detect;
	wire ssbm_ctrl1_type next_ctrl1 = {written_ctrl1.rx_fault_irq_enable,
		written_ctrl1.tx_irq_enable, next_master,
		written_ctrl1.select_output_enable, written_ctrl1.fault_detect_enable};

	// Pin drives are computed from the next mode so that they change with it.
	wire logic next_auto_select = interface_enable & next_master
		& next_ctrl1.select_output_enable & next_ctrl1.fault_detect_enable;
	wire logic slave_selected   = select_low;
	wire logic data_dir_out     = ~ctrl2.single_pin_mode | ctrl2.single_pin_output_enable;
	wire logic next_mosi_oe     = interface_enable & next_master & data_dir_out;
	wire logic next_miso_oe     = interface_enable & ~next_master & slave_selected
		& data_dir_out;
	wire logic next_sck_oe      = interface_enable & next_master;

	wire logic next_irq = ((rx_full_flag | fault_flag) & ctrl1.rx_fault_irq_enable)
		| (tx_empty_flag & ctrl1.tx_irq_enable);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			select_sync <= `SSBM_SYNC_HIGH;
		end else begin
			select_sync <= {select_sync[0], select_pin_in};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl1       <= `SSBM_CTRL1_RST;
			fault_flag  <= `SSBM_FLAG_RST;
			clear_armed <= `SSBM_FLAG_RST;
			irq         <= `SSBM_FLAG_RST;
		end else begin
			ctrl1       <= next_ctrl1;
			fault_flag  <= next_fault_flag;
			clear_armed <= next_clear_armed;
			irq         <= next_irq;
		end
	end

	// Auto select drives high while idle so the addressed slave is released.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serial_clock_pin <= `SSBM_DRIVE_RST;
			select_pin       <= `SSBM_DRIVE_RST;
			master_data_io   <= `SSBM_DRIVE_RST;
			slave_data_io    <= `SSBM_DRIVE_RST;
		end else begin
			serial_clock_pin <= make_drive(next_sck_oe, clock_gen_level);
			select_pin       <= make_drive(next_auto_select, ~transfer_active);
			master_data_io   <= make_drive(next_mosi_oe, shift_out_bit);
			slave_data_io    <= make_drive(next_miso_oe, shift_out_bit);
		end
	end

	// Helper state read by the checks below and by the link-side single-pin synchroniser.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl2_seen <= '0;
		end else begin
			ctrl2_seen <= ctrl2;
		end
	end

	// Link side. Mode bits and data pins cross as levels through two flip-flops; the
	// reset release is also synchronised so the shifter side never leaves reset
	// half-way through a serial clock period.
	logic [1:0] link_rst_sync;
	logic [1:0] link_master_sync;
	logic [1:0] link_single_sync;
	logic [1:0] link_mosi_sync;
	logic [1:0] link_miso_sync;

	wire logic link_rst = link_rst_sync[1];
	// Master reads MISO and slave MOSI; single-pin mode swaps to the shared pin.
	wire logic link_take_miso = link_master_sync[1] ^ link_single_sync[1];
	wire logic next_serial_in = link_take_miso ? link_miso_sync[1] : link_mosi_sync[1];

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			link_rst_sync <= `SSBM_SYNC_HIGH;
		end else begin
			link_rst_sync <= {link_rst_sync[0], 1'h0};
		end
	end

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			link_master_sync <= `SSBM_SYNC_LOW;
			link_single_sync <= `SSBM_SYNC_LOW;
			link_mosi_sync   <= `SSBM_SYNC_LOW;
			link_miso_sync   <= `SSBM_SYNC_LOW;
			shift_serial_in  <= `SSBM_FLAG_RST;
		end else begin
			link_master_sync <= {link_master_sync[0], ctrl1.master_select};
			link_single_sync <= {link_single_sync[0], ctrl2_seen.single_pin_mode};
			link_mosi_sync   <= {link_mosi_sync[0], master_data_io_in};
			link_miso_sync   <= {link_miso_sync[0], slave_data_io_in};
			shift_serial_in  <= next_serial_in;
		end
	end

	// Checks, all on the core clock except the link-side pick check at the end.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_status_sees_fault;
		status_read && fault_flag && !ctrl_write;
	endsequence

	sequence s_clearing_write;
		ctrl_write && !fault_detect;
	endsequence

	// Software usually leaves at least one idle cycle between the read and the write.
	sequence s_idle_gap;
		!ctrl_write && !status_read;
	endsequence

	// Everything the core drives toward the pads.
	wire logic any_pin_driven = serial_clock_pin.oe | select_pin.oe
		| master_data_io.oe | slave_data_io.oe;

	a_auto_select_low: assert property (
		(next_auto_select && transfer_active) |=> (select_pin.oe && !select_pin.out))
		else $error("auto select not low during transfer");

	a_auto_select_idle: assert property (
		(next_auto_select && !transfer_active) |=> (select_pin.oe && select_pin.out))
		else $error("auto select not high while idle");

	a_select_needs_master: assert property (
		select_pin.oe |-> (ctrl1.master_select && ctrl1.select_output_enable
			&& ctrl1.fault_detect_enable))
		else $error("select driven outside master auto select");

	a_no_fault_auto: assert property (
		$rose(fault_flag) |-> $past(fault_input_active))
		else $error("fault flagged while fault input inactive");

	a_single_pin_idle: assert property (
		(ctrl2_seen.single_pin_mode && ctrl1.master_select) |-> !slave_data_io.oe)
		else $error("unused data pin driven in single-pin master");

	a_pin_direction: assert property (
		(master_data_io.oe || slave_data_io.oe) |->
			(!ctrl2_seen.single_pin_mode || ctrl2_seen.single_pin_output_enable))
		else $error("single-pin data driven while direction is input");

	a_clock_master_only: assert property (
		serial_clock_pin.oe |-> ctrl1.master_select)
		else $error("serial clock driven in slave mode");

	a_fault_to_slave: assert property (
		fault_detect |=> (fault_flag && !ctrl1.master_select && !serial_clock_pin.oe
			&& !master_data_io.oe))
		else $error("fault did not force slave mode");

	a_fault_clear_seq: assert property (
		s_status_sees_fault ##1 s_idle_gap ##1 s_clearing_write |=> !fault_flag)
		else $error("fault flag survived read then write");

	a_fault_clear_next: assert property (
		s_status_sees_fault ##1 s_clearing_write |=> !fault_flag)
		else $error("fault flag survived back to back read and write");

	a_fault_clear_cause: assert property (
		$fell(fault_flag) |-> ($past(clear_armed) && $past(ctrl_write)))
		else $error("fault flag cleared without read then write");

	a_irq_holds: assert property (
		(tx_empty_flag && ctrl1.tx_irq_enable) [*2] |-> irq)
		else $error("interrupt request missing for enabled flag");

	a_irq_masked: assert property (
		irq |-> $past(((rx_full_flag || fault_flag) && ctrl1.rx_fault_irq_enable)
			|| (tx_empty_flag && ctrl1.tx_irq_enable)))
		else $error("interrupt request without enabled cause");

	a_irq_needs_enable: assert property (
		(!ctrl1.rx_fault_irq_enable && !ctrl1.tx_irq_enable) |=> !irq)
		else $error("interrupt request while both enables are clear");

	a_irq_drops: assert property (
		(!tx_empty_flag && !rx_full_flag && !fault_flag) |=> !irq)
		else $error("interrupt request held with no flag set");

	a_irq_rx_fault: assert property (
		((rx_full_flag || fault_flag) && ctrl1.rx_fault_irq_enable) |=> irq)
		else $error("interrupt request missing for receive or fault flag");

	a_disabled_pins_off: assert property (
		!interface_enable |=> !any_pin_driven)
		else $error("pin driven while the interface is off");

	a_select_input_slave: assert property (
		!ctrl1.master_select |-> !select_pin.oe)
		else $error("select pin driven in slave mode");

	a_single_slave_mosi: assert property (
		(ctrl2_seen.single_pin_mode && !ctrl1.master_select) |-> !master_data_io.oe)
		else $error("master data pin driven in single-pin slave mode");

	a_data_out_value: assert property (
		master_data_io.oe |-> (master_data_io.out == $past(shift_out_bit)))
		else $error("master data pin does not carry the shifter bit");

	a_slave_out_value: assert property (
		slave_data_io.oe |-> (slave_data_io.out == $past(shift_out_bit)))
		else $error("slave data pin does not carry the shifter bit");

	a_clock_out_value: assert property (
		serial_clock_pin.oe |-> (serial_clock_pin.out == $past(clock_gen_level)))
		else $error("serial clock pin does not follow the generator");

	// After a fault in single-pin mode the shared data pin moves to the slave side.
	a_fault_miso_taken: assert property (
		(ctrl2_seen.single_pin_mode && ctrl2_seen.single_pin_output_enable
			&& !ctrl1.master_select && $past(interface_enable) && $past(select_low))
			|-> (slave_data_io.oe && !master_data_io.oe))
		else $error("single-pin slave did not take over the slave data pin");

	a_fault_needs_master: assert property (
		fault_detect |-> (ctrl1.master_select && ctrl1.fault_detect_enable
			&& !ctrl1.select_output_enable))
		else $error("fault detected outside master fault input setup");

	a_fault_flag_holds: assert property (
		(fault_flag && !ctrl_write) |=> fault_flag)
		else $error("fault flag dropped without a control write");

	// A fresh fault in the clearing cycle must not be lost.
	a_set_wins_clear: assert property (
		(fault_detect && clear_write) |=> fault_flag)
		else $error("new fault lost against a clearing write");

	// The shifter input is checked on its own clock and reset.
	a_link_pick: assert property (
		@(posedge link_clk) disable iff (link_rst)
		shift_serial_in == $past(next_serial_in))
		else $error("shifter input does not follow the selected pin");

endmodule // ssbm_core

// [ssbm_peer.sv]
// Far-side model: a rival master on the select line and a talker on released data lines.
// Assumes the bench commands it; released lines toggle, or carry answer_bit when answering, so a stale value never passes.
`timescale 1ns/1ps
module ssbm_peer
	import ssbm_pkg::*;
(
	input  wire logic           link_clk,
	input  wire logic           pull_select,
	input  wire logic           answer,
	input  wire logic           answer_bit,
	input  wire ssbm_drive_type select_pin,
	input  wire ssbm_drive_type master_data_io,
	input  wire ssbm_drive_type slave_data_io,
	output logic                select_pin_in,
	output logic                master_data_io_in,
	output logic                slave_data_io_in
);
	logic toggle = 1'h0;
	wire  idle_level = answer ? answer_bit : toggle;
	always @(posedge link_clk) toggle <= ~toggle;
	// A pulled select beats our own drive, as a rival master would; released it floats high.
	assign select_pin_in     = pull_select ? 1'h0 : (select_pin.oe ? select_pin.out : 1'h1);
	assign master_data_io_in = master_data_io.oe ? master_data_io.out : idle_level;
	assign slave_data_io_in  = slave_data_io.oe ? slave_data_io.out : idle_level;
endmodule // ssbm_peer

// [testbench.sv]
// Self-checking bench for the select, single-pin and mode-fault logic.
// Assumes the far side is the peer model; notes are {care_link, link_bit, snapshot}.
`timescale 1ns/1ps
module testbench
	import ssbm_pkg::*;
;
	logic core_clk = 0, link_clk = 0, rst = 1, en = 1, wr_p = 0, rd_p = 0;
	logic rxf = 0, txe = 0, busy = 0, sob = 0, cgl = 0, pull = 0, ans = 0, abit = 0;
	ssbm_ctrl1_type wd = 5'h00, c1;
	ssbm_ctrl2_type c2 = 2'h0;
	ssbm_drive_type sck, sel, mosi, miso;
	logic ff, irq, ssi, sel_in, mosi_in, miso_in, ok;
	logic [13:0] q[$], e;
	logic [31:0] r = 32'h40;
	int n_fail = 0, comparisons = 0, i;
	event look;
	wire [11:0] snap = {ff, irq, c1, sck.oe, sel.oe, sel.out | ~sel.oe, mosi.oe, miso.oe};
	ssbm_core u_dut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
		.interface_enable(en), .ctrl_write(wr_p), .ctrl_wdata(wd), .ctrl2(c2),
		.status_read(rd_p), .rx_full_flag(rxf), .tx_empty_flag(txe), .transfer_active(busy),
		.shift_out_bit(sob), .clock_gen_level(cgl), .select_pin_in(sel_in),
		.master_data_io_in(mosi_in), .slave_data_io_in(miso_in), .ctrl1(c1), .fault_flag(ff),
		.irq(irq), .serial_clock_pin(sck), .select_pin(sel), .master_data_io(mosi),
		.slave_data_io(miso), .shift_serial_in(ssi));
	ssbm_peer u_peer (.link_clk(link_clk), .pull_select(pull), .answer(ans),
		.answer_bit(abit), .select_pin(sel), .master_data_io(mosi), .slave_data_io(miso),
		.select_pin_in(sel_in), .master_data_io_in(mosi_in), .slave_data_io_in(miso_in));
	initial forever #10 core_clk = ~core_clk;
	initial begin
		#7;
		forever #62.5 link_clk = ~link_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic note(input logic [13:0] v);
		q.push_back(v);
		-> look;
	endtask
	task automatic wr(input logic [4:0] v);
		wd = v;
		wr_p = 1;
		step(1);
		wr_p = 0;
		step(2);
	endtask
	task automatic rd();
		rd_p = 1;
		step(1);
		rd_p = 0;
		step(1);
	endtask
	task automatic wait_fault();
		ok = 0;
		for (int k = 0; k < 10 && !ok; k++) begin
			step(1);
			ok = (ff === 1'h1);
		end
		if (!ok) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, ff, 1'h1);
			complete_run();
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Oldest note is matched against the settled outputs; the link bit only when cared for.
	initial forever begin
		@(look);
		e = q.pop_front();
		comparisons++;
		if (snap !== e[11:0] || (e[13] && ssi !== e[12])) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, {ssi, snap}, e);
		end
	end
	initial begin
		step(12);
		rst = 0;
		step(1);
		note({2'h0, 1'h0, 1'h0, 5'h00, 5'h04});
		busy = 1;
		wr(5'h07);
		note({2'h0, 1'h0, 1'h0, 5'h07, 5'h1A});
		pull = 1;
		step(6);
		note({2'h0, 1'h0, 1'h0, 5'h07, 5'h1A});
		pull = 0;
		busy = 0;
		step(2);
		note({2'h0, 1'h0, 1'h0, 5'h07, 5'h1E});
		wr(5'h15);
		note({2'h0, 1'h0, 1'h0, 5'h15, 5'h16});
		pull = 1;
		wait_fault();
		pull = 0;
		step(5);
		note({2'h0, 1'h1, 1'h1, 5'h11, 5'h04});
		wr(5'h11);
		note({2'h0, 1'h1, 1'h1, 5'h11, 5'h04});
		rd();
		wr(5'h10);
		note({2'h0, 1'h0, 1'h0, 5'h10, 5'h04});
		c2 = 2'h3;
		wr(5'h05);
		note({2'h0, 1'h0, 1'h0, 5'h05, 5'h16});
		c2 = 2'h2;
		ans = 1;
		abit = 1;
		step(30);
		note({2'h3, 1'h0, 1'h0, 5'h05, 5'h14});
		c2 = 2'h3;
		pull = 1;
		wait_fault();
		step(2);
		note({2'h0, 1'h1, 1'h0, 5'h01, 5'h05});
		c2 = 2'h2;
		abit = 0;
		step(30);
		note({2'h2, 1'h1, 1'h0, 5'h01, 5'h04});
		pull = 0;
		step(5);
		rd();
		c2 = 2'h0;
		abit = 1;
		wr(5'h04);
		step(30);
		note({2'h3, 1'h0, 1'h0, 5'h04, 5'h16});
		en = 0;
		step(2);
		note({2'h0, 1'h0, 1'h0, 5'h04, 5'h04});
		en = 1;
		for (i = 0; i < 12; i++) begin
			r = r ^ (r << 13);
			r = r ^ (r >> 17);
			r = r ^ (r << 5);
			{sob, cgl, rxf, txe} = r[7:4];
			wr({r[0], r[1], 3'h0});
			step(1);
			note({2'h0, 1'h0, (r[5] & r[0]) | (r[4] & r[1]),
				r[0], r[1], 3'h0, 5'h04});
		end
		complete_run();
	end
endmodule // testbench
